/* File: logic/radio_cal_pkg.sv */
// constants, register map and types for the front-end calibration register bank
package radio_cal_pkg;

  localparam int NUM_REGS = 8;

  // register addresses on the serial port (6-bit address space)
  localparam logic [5:0] ADDR_GAIN_CONTROL_LOW    = 6'h1d;
  localparam logic [5:0] ADDR_RESERVED_TUNING_A   = 6'h20;
  localparam logic [5:0] ADDR_RX_FRONTEND_BIAS    = 6'h21;
  localparam logic [5:0] ADDR_TX_FRONTEND_CONFIG  = 6'h22;
  localparam logic [5:0] ADDR_SYNTH_CAL_PUMP      = 6'h23;
  localparam logic [5:0] ADDR_SYNTH_CAL_OSC       = 6'h24;
  localparam logic [5:0] ADDR_SYNTH_CAL_CAP_ARRAY = 6'h25;
  localparam logic [5:0] ADDR_SYNTH_CAL_CONTROL   = 6'h26;

  // slot of each register in the bank
  localparam int IDX_GAIN = 0;
  localparam int IDX_RSV  = 1;
  localparam int IDX_RXFE = 2;
  localparam int IDX_TXFE = 3;
  localparam int IDX_PUMP = 4;
  localparam int IDX_OSC  = 5;
  localparam int IDX_CAP  = 6;
  localparam int IDX_CTRL = 7;

  localparam logic [5:0] REG_ADDR [NUM_REGS] = '{
    ADDR_GAIN_CONTROL_LOW, ADDR_RESERVED_TUNING_A, ADDR_RX_FRONTEND_BIAS,
    ADDR_TX_FRONTEND_CONFIG, ADDR_SYNTH_CAL_PUMP, ADDR_SYNTH_CAL_OSC,
    ADDR_SYNTH_CAL_CAP_ARRAY, ADDR_SYNTH_CAL_CONTROL};

  localparam logic [7:0] REG_RESET [NUM_REGS] = '{
    8'h91, 8'hf8, 8'h56, 8'h10, 8'ha9, 8'h0a, 8'h20, 8'h0d};

  // writable bits; the rest are unused and read zero
  localparam logic [7:0] REG_MASK [NUM_REGS] = '{
    8'hff, 8'hfb, 8'hff, 8'h37, 8'hff, 8'h3f, 8'h3f, 8'h7f};

  // field positions
  localparam int AVG_LEN_LSB      = 0;
  localparam int GAIN_HOLD_LSB    = 2;
  localparam int MIX_BIAS_LSB     = 0;
  localparam int RX_LO_BIAS_LSB   = 2;
  localparam int AMP_MIX_BIAS_LSB = 4;
  localparam int LNA_BIAS_LSB     = 6;
  localparam int AMP_LEVEL_LSB    = 0;
  localparam int TX_LO_BIAS_LSB   = 4;
  localparam int PUMP_CUR_LSB     = 0;
  localparam int PUMP_CAL_EN_LSB  = 4;
  localparam int SYNTH_CFG_LSB    = 6;
  localparam int OSC_CUR_LSB      = 0;
  localparam int OSC_CORE_BIT     = 5;
  localparam int CAP_ARRAY_LSB    = 0;
  localparam int CAL_CTRL_LSB     = 0;

  // gain hold encodings
  localparam logic [1:0] HOLD_NONE   = 2'h0;
  localparam logic [1:0] HOLD_ON_SYNC = 2'h1;
  localparam logic [1:0] HOLD_ANALOG = 2'h2;
  localparam logic [1:0] HOLD_BOTH   = 2'h3;

  // averaging and OOK boundary scales, last amp level table entry
  localparam logic [6:0] AVG_BASE_SAMPLES = 7'h08;
  localparam logic [4:0] OOK_STEP_DB      = 5'h04;
  localparam logic [2:0] AMP_TABLE_LAST   = 3'h1;

  // serial header layout
  localparam int HDR_READ_BIT  = 7;
  localparam int HDR_BURST_BIT = 6;
  localparam logic [2:0] BIT_CNT_LAST = 3'h7;

  typedef enum logic [3:0] {
    SPI_IDLE = 4'h1,
    SPI_HEAD = 4'h2,
    SPI_DATA = 4'h4,
    SPI_SKIP = 4'h8
  } spi_state_t;

endpackage

/* File: logic/pin_sync.sv */
// two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module pin_sync
  import radio_cal_pkg::*;
#(
  parameter int WIDTH = 3
) (
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] async_in,
  input  wire logic [WIDTH-1:0] reset_level,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_d;

  for (genvar b = 0; b < WIDTH; b++) begin : g_bit
    always_comb begin
      meta_d[b] = async_in[b];
      sync_d[b] = meta_q[b];
    end

    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        meta_q[b]   <= 1'b1;
        sync_out[b] <= 1'b1;
      end else if (ce) begin
        meta_q[b]   <= meta_d[b];
        sync_out[b] <= sync_d[b];
      end
    end
  end

  // reset_level kept for interface symmetry; pins idle high after reset
  logic unused_level;
  assign unused_level = ^reset_level;

endmodule

/* File: logic/field_decode.sv */
// decodes gain, averaging, level and pump fields into registered controls
`timescale 1ns/1ps
module field_decode
  import radio_cal_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       ce,
  input  wire logic       fsk4_mode,
  input  wire logic       ook_mode,
  input  wire logic       sync_found,
  input  wire logic [1:0] gain_hold_select,
  input  wire logic [1:0] avg_len_select,
  input  wire logic [2:0] amp_level_index,
  input  wire logic [1:0] pump_cal_enable,
  output logic            hold_analog,
  output logic            hold_digital,
  output logic [6:0]      filter_avg_samples,
  output logic [4:0]      ook_boundary_db,
  output logic            amp_entry_sel,
  output logic            pump_cal_skip
);

  logic       hold_analog_d;
  logic       hold_digital_d;
  logic [6:0] samples_d;
  logic [4:0] boundary_d;
  logic       entry_d;
  logic       skip_d;

  always_comb begin
    hold_analog_d  = 1'b0;
    hold_digital_d = 1'b0;
    unique case (gain_hold_select)
      HOLD_NONE: begin
        hold_analog_d  = 1'b0;
      end
      HOLD_ON_SYNC: begin
        hold_analog_d  = sync_found;
        hold_digital_d = sync_found;
      end
      HOLD_ANALOG: begin
        hold_analog_d  = 1'b1;
      end
      HOLD_BOTH: begin
        hold_analog_d  = 1'b1;
        hold_digital_d = 1'b1;
      end
    endcase
    samples_d = fsk4_mode ? (AVG_BASE_SAMPLES << avg_len_select) : 7'h00;
    boundary_d = ook_mode ? 5'(OOK_STEP_DB * ({3'h0, avg_len_select} + 5'h01)) : 5'h00;
    // index clamped to last table entry
    entry_d = (amp_level_index >= AMP_TABLE_LAST);
    skip_d = (pump_cal_enable == 2'h0);
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      hold_analog        <= 1'b0;
      hold_digital       <= 1'b0;
      filter_avg_samples <= 7'h00;
      ook_boundary_db    <= 5'h00;
      amp_entry_sel      <= 1'b0;
      pump_cal_skip      <= 1'b0;
    end else if (ce) begin
      hold_analog        <= hold_analog_d;
      hold_digital       <= hold_digital_d;
      filter_avg_samples <= samples_d;
      ook_boundary_db    <= boundary_d;
      amp_entry_sel      <= entry_d;
      pump_cal_skip      <= skip_d;
    end
  end

  property p_hold_both;
    @(posedge core_clk) disable iff (rst)
      ce && gain_hold_select == HOLD_BOTH |=> hold_analog && hold_digital;
  endproperty
  a_hold_both: assert property (p_hold_both) else $error("hold both not applied");

  property p_hold_analog;
    @(posedge core_clk) disable iff (rst)
      ce && gain_hold_select == HOLD_ANALOG |=> hold_analog && !hold_digital;
  endproperty
  a_hold_analog: assert property (p_hold_analog) else $error("analog hold wrong");

  property p_hold_sync;
    @(posedge core_clk) disable iff (rst)
      ce && gain_hold_select == HOLD_ON_SYNC |=> hold_digital == $past(sync_found);
  endproperty
  a_hold_sync: assert property (p_hold_sync) else $error("sync hold wrong");

  property p_avg_len;
    @(posedge core_clk) disable iff (rst)
      ce && fsk4_mode && avg_len_select == 2'h3 |=> filter_avg_samples == 7'h40;
  endproperty
  a_avg_len: assert property (p_avg_len) else $error("averaging length wrong");

  property p_ook_db;
    @(posedge core_clk) disable iff (rst)
      ce && ook_mode && avg_len_select == 2'h2 |=> ook_boundary_db == 5'h0c;
  endproperty
  a_ook_db: assert property (p_ook_db) else $error("ook boundary wrong");

  property p_pump_skip;
    @(posedge core_clk) disable iff (rst)
      ce ##1 ce |-> pump_cal_skip == ($past(pump_cal_enable) == 2'h0);
  endproperty
  a_pump_skip: assert property (p_pump_skip) else $error("pump skip wrong");

endmodule

/* File: logic/radio_cal_regs.sv */
// serial-port register bank for front-end bias and synthesizer calibration
`timescale 1ns/1ps
module radio_cal_regs
  import radio_cal_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic spi_cs_n,
  input  wire logic spi_sclk,
  input  wire logic spi_si,
  output logic      spi_so,
  output logic      spi_so_oe,
  input  wire logic fsk4_mode,
  input  wire logic ook_mode,
  input  wire logic sync_found,
  output logic      hold_analog,
  output logic      hold_digital,
  output logic [6:0] filter_avg_samples,
  output logic [4:0] ook_boundary_db,
  output logic [1:0] low_noise_amp_bias,
  output logic [1:0] amp_to_mixer_bias,
  output logic [1:0] rx_local_osc_buffer_bias,
  output logic [1:0] mixer_bias,
  output logic [1:0] tx_local_osc_buffer_bias,
  output logic [2:0] amp_level_index,
  output logic      amp_entry_sel,
  output logic      pump_cal_skip,
  output logic [3:0] pump_current_exp,
  output logic [1:0] synth_cal_cfg,
  output logic      osc_core_high_select,
  output logic [4:0] osc_current_cal,
  output logic [5:0] cap_array_cal,
  output logic [6:0] synth_cal_ctrl,
  output logic [7:0] reserved_tuning
);

  logic [2:0] pins_s;
  logic       cs_n_s;
  logic       sclk_s;
  logic       si_s;

  pin_sync #(.WIDTH(3)) u_sync (
    .core_clk    (core_clk),
    .rst         (rst),
    .ce          (ce),
    .async_in    ({spi_cs_n, spi_sclk, spi_si}),
    .reset_level (3'h7),
    .sync_out    (pins_s)
  );

  assign cs_n_s = pins_s[2];
  assign sclk_s = pins_s[1];
  assign si_s   = pins_s[0];

  // serial front end state
  spi_state_t state_q;
  spi_state_t state_d;
  logic       sclk_prev_q;
  logic       sclk_prev_d;
  logic [2:0] bit_cnt_q;
  logic [2:0] bit_cnt_d;
  logic [7:0] shift_q;
  logic [7:0] shift_d;
  logic [7:0] tx_q;
  logic [7:0] tx_d;
  logic [5:0] addr_q;
  logic [5:0] addr_d;
  logic       read_q;
  logic       read_d;
  logic       burst_q;
  logic       burst_d;
  logic       wr_stb_q;
  logic       wr_stb_d;
  logic [5:0] wr_addr_q;
  logic [5:0] wr_addr_d;
  logic [7:0] wdata_q;
  logic [7:0] wdata_d;
  logic       so_d;
  logic       so_oe_d;

  logic [7:0] bank_q [NUM_REGS];
  logic [7:0] bank_d [NUM_REGS];

  logic       rise;
  logic       fall;
  logic [7:0] byte_in;
  logic [5:0] addr_next;

  assign rise      = sclk_s & ~sclk_prev_q;
  assign fall      = ~sclk_s & sclk_prev_q;
  assign byte_in   = {shift_q[6:0], si_s};
  assign addr_next = addr_q + 6'h01;

  // unmapped addresses read zero
  function automatic logic [7:0] read_value(input logic [5:0] a);
    logic [7:0] v;
    v = 8'h00;
    for (int i = 0; i < NUM_REGS; i++) begin
      if (REG_ADDR[i] == a) begin
        v = bank_q[i];
      end
    end
    return v;
  endfunction

  always_comb begin
    state_d     = state_q;
    sclk_prev_d = sclk_s;
    bit_cnt_d   = bit_cnt_q;
    shift_d     = shift_q;
    tx_d        = tx_q;
    addr_d      = addr_q;
    read_d      = read_q;
    burst_d     = burst_q;
    wr_stb_d    = 1'b0;
    wr_addr_d   = wr_addr_q;
    wdata_d     = wdata_q;
    so_d        = spi_so;
    so_oe_d     = 1'b1;
    if (cs_n_s) begin
      state_d   = SPI_IDLE;
      bit_cnt_d = 3'h0;
      // drop leftover read bits so the next header shifts out zeros
      tx_d      = 8'h00;
      so_d      = 1'b0;
      so_oe_d   = 1'b0;
    end else begin
      if (fall && state_q != SPI_IDLE) begin
        so_d = tx_q[7];
        tx_d = {tx_q[6:0], 1'b0};
      end
      unique case (state_q)
        SPI_IDLE, SPI_HEAD: begin
          state_d = SPI_HEAD;
          if (rise) begin
            shift_d   = byte_in;
            bit_cnt_d = bit_cnt_q + 3'h1;
            if (bit_cnt_q == BIT_CNT_LAST) begin
              addr_d  = byte_in[5:0];
              read_d  = byte_in[HDR_READ_BIT];
              burst_d = byte_in[HDR_BURST_BIT];
              tx_d    = read_value(byte_in[5:0]);
              state_d = SPI_DATA;
            end
          end
        end
        SPI_DATA: begin
          if (rise) begin
            shift_d   = byte_in;
            bit_cnt_d = bit_cnt_q + 3'h1;
            if (bit_cnt_q == BIT_CNT_LAST) begin
              if (!read_q) begin
                wr_stb_d  = 1'b1;
                wr_addr_d = addr_q;
                wdata_d   = byte_in;
              end
              if (burst_q) begin
                addr_d = addr_next;
                tx_d   = read_value(addr_next);
              end else begin
                state_d = SPI_SKIP;
              end
            end
          end
        end
        SPI_SKIP: begin
          state_d = SPI_SKIP;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q     <= SPI_IDLE;
      sclk_prev_q <= 1'b1;
      bit_cnt_q   <= 3'h0;
      shift_q     <= 8'h00;
      tx_q        <= 8'h00;
      addr_q      <= 6'h00;
      read_q      <= 1'b0;
      burst_q     <= 1'b0;
      wr_stb_q    <= 1'b0;
      wr_addr_q   <= 6'h00;
      wdata_q     <= 8'h00;
      spi_so      <= 1'b0;
      spi_so_oe   <= 1'b0;
    end else if (ce) begin
      state_q     <= state_d;
      sclk_prev_q <= sclk_prev_d;
      bit_cnt_q   <= bit_cnt_d;
      shift_q     <= shift_d;
      tx_q        <= tx_d;
      addr_q      <= addr_d;
      read_q      <= read_d;
      burst_q     <= burst_d;
      wr_stb_q    <= wr_stb_d;
      wr_addr_q   <= wr_addr_d;
      wdata_q     <= wdata_d;
      spi_so      <= so_d;
      spi_so_oe   <= so_oe_d;
    end
  end

  // register bank
  always_comb begin
    for (int i = 0; i < NUM_REGS; i++) begin
      bank_d[i] = bank_q[i];
      if (wr_stb_q && wr_addr_q == REG_ADDR[i]) begin
        bank_d[i] = wdata_q & REG_MASK[i];
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        bank_q[i] <= REG_RESET[i];
      end
    end else if (ce) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        bank_q[i] <= bank_d[i];
      end
    end
  end

  // fields straight from the bank
  assign reserved_tuning          = bank_q[IDX_RSV];
  assign low_noise_amp_bias       = bank_q[IDX_RXFE][LNA_BIAS_LSB +: 2];
  assign amp_to_mixer_bias        = bank_q[IDX_RXFE][AMP_MIX_BIAS_LSB +: 2];
  assign rx_local_osc_buffer_bias = bank_q[IDX_RXFE][RX_LO_BIAS_LSB +: 2];
  assign mixer_bias               = bank_q[IDX_RXFE][MIX_BIAS_LSB +: 2];
  assign tx_local_osc_buffer_bias = bank_q[IDX_TXFE][TX_LO_BIAS_LSB +: 2];
  assign amp_level_index          = bank_q[IDX_TXFE][AMP_LEVEL_LSB +: 3];
  assign pump_current_exp         = bank_q[IDX_PUMP][PUMP_CUR_LSB +: 4];
  assign synth_cal_cfg            = bank_q[IDX_PUMP][SYNTH_CFG_LSB +: 2];
  assign osc_core_high_select     = bank_q[IDX_OSC][OSC_CORE_BIT];
  assign osc_current_cal          = bank_q[IDX_OSC][OSC_CUR_LSB +: 5];
  assign cap_array_cal            = bank_q[IDX_CAP][CAP_ARRAY_LSB +: 6];
  assign synth_cal_ctrl           = bank_q[IDX_CTRL][CAL_CTRL_LSB +: 7];

  field_decode u_decode (
    .core_clk           (core_clk),
    .rst                (rst),
    .ce                 (ce),
    .fsk4_mode          (fsk4_mode),
    .ook_mode           (ook_mode),
    .sync_found         (sync_found),
    .gain_hold_select   (bank_q[IDX_GAIN][GAIN_HOLD_LSB +: 2]),
    .avg_len_select     (bank_q[IDX_GAIN][AVG_LEN_LSB +: 2]),
    .amp_level_index    (bank_q[IDX_TXFE][AMP_LEVEL_LSB +: 3]),
    .pump_cal_enable    (bank_q[IDX_PUMP][PUMP_CAL_EN_LSB +: 2]),
    .hold_analog        (hold_analog),
    .hold_digital       (hold_digital),
    .filter_avg_samples (filter_avg_samples),
    .ook_boundary_db    (ook_boundary_db),
    .amp_entry_sel      (amp_entry_sel),
    .pump_cal_skip      (pump_cal_skip)
  );

  property p_amp_entry;
    @(posedge core_clk) disable iff (rst)
      ce && amp_level_index == 3'h0 |=> !amp_entry_sel;
  endproperty
  a_amp_entry: assert property (p_amp_entry) else $error("level entry select wrong");

  property p_pump_write;
    @(posedge core_clk) disable iff (rst)
      ce && wr_stb_q && wr_addr_q == ADDR_SYNTH_CAL_PUMP
        |=> pump_current_exp == $past(wdata_q[3:0]);
  endproperty
  a_pump_write: assert property (p_pump_write) else $error("pump result not stored");

  property p_core_write;
    @(posedge core_clk) disable iff (rst)
      ce && wr_stb_q && wr_addr_q == ADDR_SYNTH_CAL_OSC
        |=> osc_core_high_select == $past(wdata_q[5]);
  endproperty
  a_core_write: assert property (p_core_write) else $error("core select not stored");

  property p_osc_override;
    @(posedge core_clk) disable iff (rst)
      ce && wr_stb_q && wr_addr_q == ADDR_SYNTH_CAL_OSC
        |=> osc_current_cal == $past(wdata_q[4:0]);
  endproperty
  a_osc_override: assert property (p_osc_override) else $error("osc override lost");

  property p_cap_reset;
    @(posedge core_clk) disable iff (rst)
      $fell(rst) |-> cap_array_cal == 6'h20;
  endproperty
  a_cap_reset: assert property (p_cap_reset) else $error("cap array reset wrong");

  property p_unused_zero;
    @(posedge core_clk) disable iff (rst)
      ce && wr_stb_q && wr_addr_q == ADDR_TX_FRONTEND_CONFIG
        |=> bank_q[IDX_TXFE][7:6] == 2'h0 && !bank_q[IDX_TXFE][3];
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused bits stored");

  property p_hold_value;
    @(posedge core_clk) disable iff (rst)
      !wr_stb_q |=> $stable(cap_array_cal) && $stable(synth_cal_ctrl);
  endproperty
  a_hold_value: assert property (p_hold_value) else $error("field changed unwritten");

  property p_read_load;
    @(posedge core_clk) disable iff (rst)
      ce && !cs_n_s && state_q == SPI_HEAD && rise && bit_cnt_q == BIT_CNT_LAST
        && byte_in[5:0] == ADDR_SYNTH_CAL_CAP_ARRAY
        |=> tx_q == {2'h0, cap_array_cal} || $past(wr_stb_q);
  endproperty
  a_read_load: assert property (p_read_load) else $error("read data not loaded");

endmodule

/* File: verification/radio_frontend_cal_config_regs_test.sv */
// self-checking bench for the front-end calibration register bank
`timescale 1ns/1ps
module radio_frontend_cal_config_regs_test
  import radio_cal_pkg::*;
;
  logic       core_clk;
  logic       rst;
  logic       ce;
  logic       spi_cs_n;
  logic       spi_sclk;
  logic       spi_si;
  logic       spi_so;
  logic       spi_so_oe;
  logic       fsk4_mode;
  logic       ook_mode;
  logic       sync_found;
  logic       hold_analog;
  logic       hold_digital;
  logic [6:0] filter_avg_samples;
  logic [4:0] ook_boundary_db;
  logic [1:0] low_noise_amp_bias;
  logic [1:0] amp_to_mixer_bias;
  logic [1:0] rx_local_osc_buffer_bias;
  logic [1:0] mixer_bias;
  logic [1:0] tx_local_osc_buffer_bias;
  logic [2:0] amp_level_index;
  logic       amp_entry_sel;
  logic       pump_cal_skip;
  logic [3:0] pump_current_exp;
  logic [1:0] synth_cal_cfg;
  logic       osc_core_high_select;
  logic [4:0] osc_current_cal;
  logic [5:0] cap_array_cal;
  logic [6:0] synth_cal_ctrl;
  logic [7:0] reserved_tuning;
  int         miscompares;
  int         checks_done;

  radio_cal_regs radio_cal_regs_inst (
    .core_clk                 (core_clk),
    .rst                      (rst),
    .ce                       (ce),
    .spi_cs_n                 (spi_cs_n),
    .spi_sclk                 (spi_sclk),
    .spi_si                   (spi_si),
    .spi_so                   (spi_so),
    .spi_so_oe                (spi_so_oe),
    .fsk4_mode                (fsk4_mode),
    .ook_mode                 (ook_mode),
    .sync_found               (sync_found),
    .hold_analog              (hold_analog),
    .hold_digital             (hold_digital),
    .filter_avg_samples       (filter_avg_samples),
    .ook_boundary_db          (ook_boundary_db),
    .low_noise_amp_bias       (low_noise_amp_bias),
    .amp_to_mixer_bias        (amp_to_mixer_bias),
    .rx_local_osc_buffer_bias (rx_local_osc_buffer_bias),
    .mixer_bias               (mixer_bias),
    .tx_local_osc_buffer_bias (tx_local_osc_buffer_bias),
    .amp_level_index          (amp_level_index),
    .amp_entry_sel            (amp_entry_sel),
    .pump_cal_skip            (pump_cal_skip),
    .pump_current_exp         (pump_current_exp),
    .synth_cal_cfg            (synth_cal_cfg),
    .osc_core_high_select     (osc_core_high_select),
    .osc_current_cal          (osc_current_cal),
    .cap_array_cal            (cap_array_cal),
    .synth_cal_ctrl           (synth_cal_ctrl),
    .reserved_tuning          (reserved_tuning)
  );

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // sclk halves of 6 clocks, well above the synchroniser minimum
  task automatic shift(input logic [7:0] tx, input int n, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 0; i < n; i++) begin
      spi_si <= tx[7-i];
      tick(6);
      rx[7-i] = spi_so;
      spi_sclk <= 1'b1;
      tick(6);
      spi_sclk <= 1'b0;
    end
  endtask

  task automatic xfer(input logic [7:0] hdr, input logic [7:0] wd, output logic [7:0] rd);
    logic [7:0] junk;
    spi_cs_n <= 1'b0;
    tick(4);
    shift(hdr, 8, junk);
    chk("output enable busy", 8'h01, {7'h00, spi_so_oe});
    shift(wd, 8, rd);
    tick(6);
    spi_cs_n <= 1'b1;
    tick(6);
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] r;
    xfer({2'b00, a}, d, r);
  endtask

  task automatic rd_chk(input logic [5:0] a, input logic [7:0] exp);
    logic [7:0] r;
    string      nm;
    nm = $sformatf("register %h", a);
    xfer({2'b10, a}, 8'h00, r);
    chk(nm, exp, r);
    chk("output enable idle", 8'h00, {7'h00, spi_so_oe});
  endtask

  task automatic results();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    tick(80000);
    miscompares++;
    results();
  end

  initial begin
    logic [7:0] r;
    logic       ea;
    logic       ed;
    rst = 1'b1;
    ce = 1'b1;
    spi_cs_n = 1'b1;
    spi_sclk = 1'b0;
    spi_si = 1'b0;
    fsk4_mode = 1'b0;
    ook_mode = 1'b0;
    sync_found = 1'b0;
    miscompares = 0;
    checks_done = 0;
    tick(12);
    rst <= 1'b0;
    tick(4);
    chk("cap array out", 8'h20, {2'b00, cap_array_cal});
    r = {low_noise_amp_bias, amp_to_mixer_bias, rx_local_osc_buffer_bias, mixer_bias};
    chk("rx bias", 8'h56, r);
    chk("reserved out", 8'hf8, reserved_tuning);
    chk("cal ctrl out", 8'h0d, {1'b0, synth_cal_ctrl});
    for (int k = 0; k < NUM_REGS; k++) rd_chk(REG_ADDR[k], REG_RESET[k]);
    for (int k = 0; k < NUM_REGS; k++) begin
      wr(REG_ADDR[k], 8'hff);
      rd_chk(REG_ADDR[k], REG_MASK[k]);
      wr(REG_ADDR[k], 8'h00);
      rd_chk(REG_ADDR[k], 8'h00);
    end
    wr(ADDR_RX_FRONTEND_BIAS, 8'he4);
    r = {low_noise_amp_bias, amp_to_mixer_bias, rx_local_osc_buffer_bias, mixer_bias};
    chk("rx bias", 8'he4, r);
    wr(6'h1e, 8'h5a);
    rd_chk(6'h1e, 8'h00);
    wr(ADDR_SYNTH_CAL_OSC, 8'h25);
    chk("core select", 8'h01, {7'h00, osc_core_high_select});
    chk("osc current", 8'h05, {3'h0, osc_current_cal});
    wr(ADDR_SYNTH_CAL_OSC, 8'hda);
    chk("core select", 8'h00, {7'h00, osc_core_high_select});
    chk("osc current", 8'h1a, {3'h0, osc_current_cal});
    wr(ADDR_SYNTH_CAL_CAP_ARRAY, 8'h2b);
    chk("cap array out", 8'h2b, {2'b00, cap_array_cal});
    for (int v = 0; v < 4; v++) begin
      wr(ADDR_SYNTH_CAL_PUMP, {2'b10, v[1:0], 4'hc});
      chk("pump skip", {7'h00, v == 0}, {7'h00, pump_cal_skip});
      chk("pump current", 8'h0c, {4'h0, pump_current_exp});
      chk("pump cfg", 8'h02, {6'h00, synth_cal_cfg});
    end
    for (int v = 0; v < 8; v++) begin
      wr(ADDR_TX_FRONTEND_CONFIG, {4'h1, 1'b0, v[2:0]});
      chk("amp index", v[7:0], {5'h00, amp_level_index});
      chk("amp entry", {7'h00, v >= 1}, {7'h00, amp_entry_sel});
      chk("tx bias", 8'h01, {6'h00, tx_local_osc_buffer_bias});
    end
    for (int v = 0; v < 4; v++) begin
      wr(ADDR_TX_FRONTEND_CONFIG, 8'h10);
      wr(ADDR_GAIN_CONTROL_LOW, {4'h9, v[1:0], v[1:0]});
      fsk4_mode <= 1'b1;
      ook_mode <= 1'b0;
      sync_found <= 1'b0;
      tick(4);
      ea = (v >= 2);
      ed = (v == 3);
      chk("avg samples", 8'h08 << v, {1'b0, filter_avg_samples});
      chk("ook off", 8'h00, {3'h0, ook_boundary_db});
      chk("hold pair", {6'h00, ea, ed}, {6'h00, hold_analog, hold_digital});
      wr(ADDR_TX_FRONTEND_CONFIG, 8'h11);
      fsk4_mode <= 1'b0;
      ook_mode <= 1'b1;
      sync_found <= 1'b1;
      tick(4);
      ea = (v != 0);
      ed = (v == 1 || v == 3);
      chk("avg off", 8'h00, {1'b0, filter_avg_samples});
      chk("ook boundary", 8'(4 * (v + 1)), {3'h0, ook_boundary_db});
      chk("hold pair", {6'h00, ea, ed}, {6'h00, hold_analog, hold_digital});
    end
    // clock enable low freezes the decoded outputs
    ce <= 1'b0;
    fsk4_mode <= 1'b1;
    ook_mode <= 1'b0;
    tick(4);
    chk("frozen avg", 8'h00, {1'b0, filter_avg_samples});
    chk("frozen ook", 8'h10, {3'h0, ook_boundary_db});
    ce <= 1'b1;
    tick(4);
    chk("avg samples", 8'h40, {1'b0, filter_avg_samples});
    // burst write then burst read across three registers
    spi_cs_n <= 1'b0;
    tick(4);
    shift({2'b01, ADDR_SYNTH_CAL_OSC}, 8, r);
    shift(8'hf3, 8, r);
    shift(8'h15, 8, r);
    shift(8'hcd, 8, r);
    tick(6);
    spi_cs_n <= 1'b1;
    tick(6);
    chk("cal ctrl out", 8'h4d, {1'b0, synth_cal_ctrl});
    spi_cs_n <= 1'b0;
    tick(4);
    shift({2'b11, ADDR_SYNTH_CAL_OSC}, 8, r);
    shift(8'h00, 8, r);
    chk("burst 0", 8'h33, r);
    shift(8'h00, 8, r);
    chk("burst 1", 8'h15, r);
    shift(8'h00, 8, r);
    chk("burst 2", 8'h4d, r);
    tick(6);
    spi_cs_n <= 1'b1;
    tick(6);
    // single write with trailing byte, then an aborted partial byte
    spi_cs_n <= 1'b0;
    tick(4);
    shift({2'b00, ADDR_SYNTH_CAL_CAP_ARRAY}, 8, r);
    shift(8'h2a, 8, r);
    shift(8'h3c, 8, r);
    shift({2'b00, ADDR_SYNTH_CAL_CAP_ARRAY}, 8, r);
    shift(8'h07, 4, r);
    tick(6);
    spi_cs_n <= 1'b1;
    tick(6);
    // partial data byte dropped when select rises
    spi_cs_n <= 1'b0;
    tick(4);
    shift({2'b00, ADDR_SYNTH_CAL_CONTROL}, 8, r);
    shift(8'h7f, 4, r);
    tick(6);
    spi_cs_n <= 1'b1;
    tick(6);
    rd_chk(ADDR_SYNTH_CAL_CAP_ARRAY, 8'h2a);
    rd_chk(ADDR_SYNTH_CAL_CONTROL, 8'h4d);
    // second reset in mid-run restores defaults
    rst <= 1'b1;
    tick(3);
    rst <= 1'b0;
    tick(4);
    chk("cap array out", 8'h20, {2'b00, cap_array_cal});
    rd_chk(ADDR_SYNTH_CAL_CONTROL, 8'h0d);
    results();
  end
endmodule
